// ===== hw/app_pkg.sv
package app_pkg;

   // Register bus geometry. Printed word indices are not byte addresses, so byte address = index * 4.
   localparam int unsigned ADDR_W = 14;
   localparam logic [11:0] IDX_OPTIONS = 12'h306;
   localparam logic [11:0] IDX_FILTER_ONE = 12'h307;
   localparam logic [11:0] IDX_RATE_TWO = 12'h308;
   localparam logic [ADDR_W-1:0] ADDR_OPTIONS = {IDX_OPTIONS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_FILTER_ONE = {IDX_FILTER_ONE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_RATE_TWO = {IDX_RATE_TWO, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 14'h0000;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 14'h0004;
   localparam logic [ADDR_W-1:0] ADDR_WORK_ZERO = 14'h0008;
   localparam logic [ADDR_W-1:0] ADDR_WORK_RATE = 14'h000C;
   localparam logic [ADDR_W-1:0] ADDR_MIN_MAX = 14'h0010;
   localparam logic [ADDR_W-1:0] ADDR_CLAMP = 14'h0014;
   localparam logic [ADDR_W-1:0] ADDR_GAIN = 14'h0018;
   localparam logic [ADDR_W-1:0] ADDR_SEG_OFFSET = 14'h001C;
   localparam logic [ADDR_W-1:0] ADDR_ANGLE = 14'h0020;
   localparam logic [ADDR_W-1:0] ADDR_WORK_FILTER = 14'h0024;
   localparam logic [ADDR_W-1:0] ADDR_SEG_BASE = 14'h0040;
   localparam logic [ADDR_W-1:0] ADDR_SEG_MASK = 14'h3FC0;
   localparam logic [15:0] EXT_CMD_RATE = 16'hFFD0;

   // Options word field positions.
   localparam int unsigned BIT_HALF_TURN = 23;
   localparam int unsigned BIT_REF_PICK = 22;
   localparam int unsigned BIT_COEFF_BYPASS = 21;
   localparam int unsigned BIT_SHORT_STROKE = 20;
   localparam int unsigned BIT_RESERVED = 19;
   localparam int unsigned BIT_INVERT = 18;
   localparam int unsigned BIT_POST_SENSE = 17;
   localparam int unsigned BIT_SEG_EN = 16;
   localparam int unsigned BIT_HARM_EN = 15;
   localparam int unsigned BIT_PRE_SENSE = 14;
   localparam int unsigned BIT_SMOOTH_EN = 12;
   localparam int unsigned ZERO_MSB = 11;
   localparam int unsigned OPT_LSB = 12;

   // Filter and rate word fields.
   localparam int unsigned SCRATCH_MSB = 23;
   localparam int unsigned SCRATCH_LSB = 20;
   localparam int unsigned THR_MSB = 19;
   localparam int unsigned THR_LSB = 16;
   localparam int unsigned COEFF_MSB = 15;
   localparam int unsigned RATE_MSB = 23;
   localparam int unsigned RATE_LSB = 21;
   localparam int unsigned BIT_SELFTEST_DIS = 20;

   // Reset values of the stored words.
   localparam logic [23:0] OPTIONS_RST = 24'h000000;
   localparam logic [23:0] FILTER_ONE_RST = 24'h0000AA;
   localparam logic [23:0] RATE_TWO_RST = 24'h000156;
   localparam logic [11:0] GAIN_RST = 12'h100;

   // Angle arithmetic.
   localparam logic [15:0] HALF_TURN = 16'h8000;
   localparam int unsigned GAIN_FRAC = 8;
   localparam int unsigned COEFF_FRAC = 15;
   localparam int unsigned SEG_IDX_MSB = 15;
   localparam int unsigned SEG_IDX_LSB = 12;
   localparam int unsigned AVG_MAX_LOG = 7;

   // Timing.
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SELFTEST_US = 100;
   localparam int unsigned SELFTEST_CYC = (SELFTEST_US * 1000) / CLK_PERIOD_NS;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {APP_INIT_COPY, APP_INIT_SELFTEST, APP_INIT_RUN} app_init_t;
   typedef enum logic [2:0] {APP_P_IDLE, APP_P_FILT, APP_P_SEG, APP_P_POST, APP_P_FIN} app_step_t;

endpackage : app_pkg

// ===== hw/app_seg_mem.sv
`timescale 1ns/1ps
`default_nettype none

// Segment coefficient table, one signed word per 22.5 degree segment.
module app_seg_mem
(
   // Clock.
   input wire logic core_clk_i,
   input wire logic ce_i,
   // Write port.
   input wire logic wr_en_i,
   input wire logic [3:0] wr_addr_i,
   input wire logic [15:0] wr_data_i,
   // Read port.
   input wire logic rd_en_i,
   input wire logic [3:0] rd_addr_i,
   output logic [15:0] rd_data_o
);

   logic [15:0] mem [0:15];

   always_ff @(posedge core_clk_i)
   begin
      if (ce_i && wr_en_i)
      begin
         mem[wr_addr_i] <= wr_data_i;
      end
      if (ce_i && rd_en_i)
      begin
         rd_data_o <= mem[rd_addr_i];
      end
   end

endmodule : app_seg_mem

`default_nettype wire

// ===== hw/app_angle_post.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - A set half-turn bit adds 180 degrees to the final angle, wrapping, last.
// - Reference pick chooses segment index from external encoder (0) or own angle (1).
// - Coefficient bypass applies only the segment offset, not the segment coefficients.
// - Short stroke enables min, max, clamp high, clamp low and gain processing.
// - Invert outputs high clamp minus calculated angle.
// - Post-linearization turn sense 1 makes counterclockwise increase the angle.
// - Segmented linearization runs only while its enable is set.
// - Harmonic linearization runs only while its enable is set.
// - Pre-linearization turn sense 1 makes counterclockwise increase the angle.
// - Smoothing enable filters the input angle before linearization with the coefficients.
// - Zero reference offset is subtracted from the angle after linearization.
// - Init loads stored 12-bit offset into working bits 15:4, bits 3:0 zero.
// - Average 2 to the n samples, n being the output averaging rate.
// - Working averaging rate stays readable and writable after initialization.
// - The 4-bit user scratch field is plain storage without effect.
// - Init loads the filter reset threshold into the working filter error field.
// - Init loads both filter numerator coefficients into their working fields.
// - Unless disabled, a 100 us memory self-test delays first angle data.
module app_angle_post
(
   // Clock, reset and enable.
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Angle stream from the front end, same clock.
   input wire logic angle_valid_i,
   input wire logic [15:0] angle_i,
   input wire logic [15:0] ext_encoder_angle_i,
   input wire logic [15:0] harmonic_corr_i,
   // Processed angle.
   output logic angle_valid_o,
   output logic [15:0] angle_o,
   output logic init_done_o,
   // AXI4-Lite write channels.
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [app_pkg::ADDR_W-1:0] awaddr_i,
   input wire logic wvalid_i,
   output logic wready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   output logic bvalid_o,
   input wire logic bready_i,
   output logic [1:0] bresp_o,
   // AXI4-Lite read channels.
   input wire logic arvalid_i,
   output logic arready_o,
   input wire logic [app_pkg::ADDR_W-1:0] araddr_i,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o
);

   // Stored words and tuning registers.
   logic [23:0] options_ff;
   logic [23:0] filter_one_ff;
   logic [23:0] rate_two_ff;
   logic [15:0] min_ff, max_ff, clamp_lo_ff, clamp_hi_ff, seg_offset_ff;
   logic [11:0] gain_ff;
   // Working fields.
   logic [23:app_pkg::OPT_LSB] work_opts_ff;
   logic [15:0] work_zero_ff;
   logic [2:0] work_rate_ff;
   logic [3:0] work_thr_ff;
   logic [15:0] work_c1_ff, work_c2_ff;
   // Bus state.
   logic aw_hold_ff, w_hold_ff;
   logic [app_pkg::ADDR_W-1:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   // Sequencing.
   app_pkg::app_init_t init_ff;
   app_pkg::app_step_t step_ff;
   logic [9:0] bist_cnt_ff;
   logic init_req_ff;
   logic [15:0] work_a_ff, filt_y_ff, seg_ref_ff;
   logic [22:0] acc_ff;
   logic [6:0] avg_cnt_ff;

   localparam int unsigned OPT_LSB_W = app_pkg::OPT_LSB;
   localparam logic [9:0] BIST_LAST = 10'(app_pkg::SELFTEST_CYC - 1);

   // Write decode.
   wire wr_go = aw_hold_ff && w_hold_ff && !bvalid_o;
   wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
   wire hit_opt = (waddr_ff == app_pkg::ADDR_OPTIONS);
   wire hit_f1 = (waddr_ff == app_pkg::ADDR_FILTER_ONE);
   wire hit_r2 = (waddr_ff == app_pkg::ADDR_RATE_TWO);
   wire hit_ctrl = (waddr_ff == app_pkg::ADDR_CTRL);
   wire hit_zero = (waddr_ff == app_pkg::ADDR_WORK_ZERO);
   wire hit_rate = (waddr_ff == app_pkg::ADDR_WORK_RATE);
   wire hit_mm = (waddr_ff == app_pkg::ADDR_MIN_MAX);
   wire hit_cl = (waddr_ff == app_pkg::ADDR_CLAMP);
   wire hit_gain = (waddr_ff == app_pkg::ADDR_GAIN);
   wire hit_soff = (waddr_ff == app_pkg::ADDR_SEG_OFFSET);
   wire hit_seg = ((waddr_ff & app_pkg::ADDR_SEG_MASK) == app_pkg::ADDR_SEG_BASE);
   wire hit_ro = (waddr_ff == app_pkg::ADDR_STATUS) || (waddr_ff == app_pkg::ADDR_ANGLE)
      || (waddr_ff == app_pkg::ADDR_WORK_FILTER);
   wire wr_ok = hit_opt || hit_f1 || hit_r2 || hit_ctrl || hit_zero || hit_rate || hit_mm
      || hit_cl || hit_gain || hit_soff || hit_seg || hit_ro;
   wire [31:0] merge_opt = ({8'h00, options_ff} & ~wmask) | (wdata_ff & wmask);
   wire [31:0] merge_f1 = ({8'h00, filter_one_ff} & ~wmask) | (wdata_ff & wmask);
   wire [31:0] merge_r2 = ({8'h00, rate_two_ff} & ~wmask) | (wdata_ff & wmask);
   wire [31:0] merge_mm = ({max_ff, min_ff} & ~wmask) | (wdata_ff & wmask);
   wire [31:0] merge_cl = ({clamp_hi_ff, clamp_lo_ff} & ~wmask) | (wdata_ff & wmask);
   wire [31:0] merge_lo = ({16'h0000, seg_offset_ff} & ~wmask) | (wdata_ff & wmask);
   wire [31:0] merge_gn = ({20'h00000, gain_ff} & ~wmask) | (wdata_ff & wmask);
   wire [31:0] merge_zr = ({16'h0000, work_zero_ff} & ~wmask) | (wdata_ff & wmask);
   wire [31:0] merge_rt = ({29'h00000000, work_rate_ff} & ~wmask) | (wdata_ff & wmask);
   wire do_copy = (init_ff == app_pkg::APP_INIT_COPY);
   wire running = (init_ff == app_pkg::APP_INIT_RUN);

   // Read decode.
   wire [31:0] status_word = {28'h0000000, step_ff == app_pkg::APP_P_IDLE, running, 2'(init_ff)};
   wire [31:0] rd_mux =
      (araddr_i == app_pkg::ADDR_OPTIONS) ? {8'h00, options_ff} :
      (araddr_i == app_pkg::ADDR_FILTER_ONE) ? {8'h00, filter_one_ff} :
      (araddr_i == app_pkg::ADDR_RATE_TWO) ? {8'h00, rate_two_ff} :
      (araddr_i == app_pkg::ADDR_STATUS) ? status_word :
      (araddr_i == app_pkg::ADDR_WORK_ZERO) ? {16'h0000, work_zero_ff} :
      (araddr_i == app_pkg::ADDR_WORK_RATE) ? {29'h00000000, work_rate_ff} :
      (araddr_i == app_pkg::ADDR_MIN_MAX) ? {max_ff, min_ff} :
      (araddr_i == app_pkg::ADDR_CLAMP) ? {clamp_hi_ff, clamp_lo_ff} :
      (araddr_i == app_pkg::ADDR_GAIN) ? {20'h00000, gain_ff} :
      (araddr_i == app_pkg::ADDR_SEG_OFFSET) ? {16'h0000, seg_offset_ff} :
      (araddr_i == app_pkg::ADDR_ANGLE) ? {16'h0000, angle_o} :
      (araddr_i == app_pkg::ADDR_WORK_FILTER) ? {work_c2_ff[11:0], work_thr_ff, work_c1_ff} :
      32'h00000000;
   wire rd_ok = ((araddr_i <= app_pkg::ADDR_WORK_FILTER) && (araddr_i[1:0] == 2'b00))
      || (araddr_i == app_pkg::ADDR_OPTIONS) || (araddr_i == app_pkg::ADDR_FILTER_ONE)
      || (araddr_i == app_pkg::ADDR_RATE_TWO)
      || ((araddr_i & app_pkg::ADDR_SEG_MASK) == app_pkg::ADDR_SEG_BASE);

   // Write address and data are accepted in either order, then answered together.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         waddr_ff <= '0;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bvalid_o <= 1'b0;
         bresp_o <= app_pkg::RESP_OKAY;
      end
      else if (ce_i)
      begin
         if (awvalid_i && awready_o)
         begin
            aw_hold_ff <= 1'b1;
            waddr_ff <= awaddr_i;
         end
         if (wvalid_i && wready_o)
         begin
            w_hold_ff <= 1'b1;
            wdata_ff <= wdata_i;
            wstrb_ff <= wstrb_i;
         end
         if (wr_go)
         begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_o <= 1'b1;
            bresp_o <= wr_ok ? app_pkg::RESP_OKAY : app_pkg::RESP_SLVERR;
         end
         else if (bvalid_o && bready_i)
         begin
            bvalid_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         awready_o <= 1'b1;
         wready_o <= 1'b1;
      end
      else if (ce_i)
      begin
         awready_o <= !(aw_hold_ff || (awvalid_i && awready_o)) || (bvalid_o && bready_i);
         wready_o <= !(w_hold_ff || (wvalid_i && wready_o)) || (bvalid_o && bready_i);
      end
   end

   // Single read outstanding; answer on the same edge that takes the address.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         arready_o <= 1'b1;
         rvalid_o <= 1'b0;
         rdata_o <= 32'h00000000;
         rresp_o <= app_pkg::RESP_OKAY;
      end
      else if (ce_i)
      begin
         if (arvalid_i && arready_o)
         begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b1;
            rdata_o <= rd_mux;
            rresp_o <= rd_ok ? app_pkg::RESP_OKAY : app_pkg::RESP_SLVERR;
         end
         else if (rvalid_o && rready_i)
         begin
            rvalid_o <= 1'b0;
            arready_o <= 1'b1;
         end
      end
   end

   // Stored words and tuning registers; scratch bits are kept and read back only.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         options_ff <= app_pkg::OPTIONS_RST;
         filter_one_ff <= app_pkg::FILTER_ONE_RST;
         rate_two_ff <= app_pkg::RATE_TWO_RST;
         min_ff <= 16'h0000;
         max_ff <= 16'hFFFF;
         clamp_lo_ff <= 16'h0000;
         clamp_hi_ff <= 16'hFFFF;
         gain_ff <= app_pkg::GAIN_RST;
         seg_offset_ff <= 16'h0000;
      end
      else if (ce_i && wr_go)
      begin
         if (hit_opt) options_ff <= merge_opt[23:0];
         if (hit_f1) filter_one_ff <= merge_f1[23:0];
         if (hit_r2) rate_two_ff <= merge_r2[23:0];
         if (hit_mm) {max_ff, min_ff} <= merge_mm;
         if (hit_cl) {clamp_hi_ff, clamp_lo_ff} <= merge_cl;
         if (hit_gain) gain_ff <= merge_gn[11:0];
         if (hit_soff) seg_offset_ff <= merge_lo[15:0];
      end
   end

   // Working fields: copied at init, then only the working copy steers processing.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         work_opts_ff <= '0;
         work_zero_ff <= 16'h0000;
         work_rate_ff <= 3'h0;
         work_thr_ff <= 4'h0;
         work_c1_ff <= 16'h0000;
         work_c2_ff <= 16'h0000;
      end
      else if (ce_i && do_copy)
      begin
         work_opts_ff <= options_ff[23:OPT_LSB_W];
         work_zero_ff <= {options_ff[app_pkg::ZERO_MSB:0], 4'h0};
         work_rate_ff <= rate_two_ff[app_pkg::RATE_MSB:app_pkg::RATE_LSB];
         work_thr_ff <= filter_one_ff[app_pkg::THR_MSB:app_pkg::THR_LSB];
         work_c1_ff <= filter_one_ff[app_pkg::COEFF_MSB:0];
         work_c2_ff <= rate_two_ff[app_pkg::COEFF_MSB:0];
      end
      else if (ce_i && wr_go)
      begin
         if (hit_zero) work_zero_ff <= merge_zr[15:0];
         if (hit_rate) work_rate_ff <= merge_rt[2:0];
      end
   end

   // Init: copy, optional memory self-test, then run. A control write with bit 0 set restarts it from run.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         init_ff <= app_pkg::APP_INIT_COPY;
         bist_cnt_ff <= 10'h000;
         init_req_ff <= 1'b0;
         init_done_o <= 1'b0;
      end
      else if (ce_i)
      begin
         init_req_ff <= wr_go && hit_ctrl && wdata_ff[0] && wstrb_ff[0];
         init_done_o <= running && !init_req_ff;
         unique case (init_ff)
            app_pkg::APP_INIT_COPY:
            begin
               bist_cnt_ff <= 10'h000;
               init_ff <= rate_two_ff[app_pkg::BIT_SELFTEST_DIS] ? app_pkg::APP_INIT_RUN
                  : app_pkg::APP_INIT_SELFTEST;
            end
            app_pkg::APP_INIT_SELFTEST:
            begin
               bist_cnt_ff <= bist_cnt_ff + 10'h001;
               if (bist_cnt_ff == BIST_LAST) init_ff <= app_pkg::APP_INIT_RUN;
            end
            app_pkg::APP_INIT_RUN:
            begin
               if (init_req_ff) init_ff <= app_pkg::APP_INIT_COPY;
            end
            default:
            begin
               init_ff <= app_pkg::APP_INIT_COPY;
            end
         endcase
      end
   end

   // Segment coefficient table.
   logic [15:0] seg_coeff;
   wire seg_wr = ce_i && wr_go && hit_seg;
   wire seg_rd = (step_ff == app_pkg::APP_P_FILT);

   app_seg_mem u_seg_mem
   (
      .core_clk_i(core_clk_i),
      .ce_i(ce_i),
      .wr_en_i(seg_wr),
      .wr_addr_i(waddr_ff[5:2]),
      .wr_data_i(wdata_ff[15:0]),
      .rd_en_i(seg_rd),
      .rd_addr_i(seg_ref_ff[app_pkg::SEG_IDX_MSB:app_pkg::SEG_IDX_LSB]),
      .rd_data_o(seg_coeff)
   );

   // Datapath terms for each step.
   wire opt_half = work_opts_ff[app_pkg::BIT_HALF_TURN];
   wire opt_pick = work_opts_ff[app_pkg::BIT_REF_PICK];
   wire opt_byp = work_opts_ff[app_pkg::BIT_COEFF_BYPASS];
   wire opt_ss = work_opts_ff[app_pkg::BIT_SHORT_STROKE];
   wire opt_inv = work_opts_ff[app_pkg::BIT_INVERT];
   wire opt_post = work_opts_ff[app_pkg::BIT_POST_SENSE];
   wire opt_seg = work_opts_ff[app_pkg::BIT_SEG_EN];
   wire opt_harm = work_opts_ff[app_pkg::BIT_HARM_EN];
   wire opt_pre = work_opts_ff[app_pkg::BIT_PRE_SENSE];
   wire opt_smooth = work_opts_ff[app_pkg::BIT_SMOOTH_EN];

   wire [15:0] pre_angle = opt_pre ? 16'(-angle_i) : angle_i;
   wire signed [33:0] filt_sum = 34'($signed({1'b0, work_a_ff}) * $signed(work_c1_ff))
      + 34'($signed({1'b0, filt_y_ff}) * $signed(work_c2_ff));
   wire [16:0] filt_err = {1'b0, work_a_ff} - {1'b0, filt_y_ff};
   wire [15:0] filt_mag = filt_err[16] ? 16'(-filt_err) : filt_err[15:0];
   wire filt_jump = filt_mag > {work_thr_ff, 12'h000};
   wire [15:0] filt_out = filt_jump ? work_a_ff : filt_sum[app_pkg::COEFF_FRAC+15:app_pkg::COEFF_FRAC];
   wire [15:0] seg_add = opt_byp ? 16'h0000 : seg_coeff;
   wire [15:0] seg_out = opt_seg ? 16'(work_a_ff + seg_add + seg_offset_ff) : work_a_ff;
   wire [15:0] lin_out = opt_harm ? 16'(seg_out + harmonic_corr_i) : seg_out;
   wire [15:0] post_angle = opt_post ? 16'(-work_a_ff) : work_a_ff;
   wire [15:0] ss_lim = (post_angle < min_ff) ? min_ff : ((post_angle > max_ff) ? max_ff : post_angle);
   wire [27:0] ss_prod = {12'h000, 16'(ss_lim - min_ff)} * {16'h0000, gain_ff};
   wire [19:0] ss_scaled = ss_prod[app_pkg::GAIN_FRAC+19:app_pkg::GAIN_FRAC];
   wire [15:0] ss_out = (ss_scaled < {4'h0, clamp_lo_ff}) ? clamp_lo_ff
      : ((ss_scaled > {4'h0, clamp_hi_ff}) ? clamp_hi_ff : ss_scaled[15:0]);
   wire [15:0] inv_out = opt_inv ? 16'(clamp_hi_ff - work_a_ff) : work_a_ff;
   wire [15:0] fin_val = 16'(inv_out - work_zero_ff);
   wire [22:0] acc_sum = acc_ff + {7'h00, fin_val};
   wire [6:0] avg_last = 7'((8'h01 << work_rate_ff) - 8'h01);
   wire [15:0] avg_val = 16'(acc_sum >> work_rate_ff);

   // One sample walks idle, filter, segment, post, finish.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         step_ff <= app_pkg::APP_P_IDLE;
         work_a_ff <= 16'h0000;
         filt_y_ff <= 16'h0000;
         seg_ref_ff <= 16'h0000;
      end
      else if (ce_i)
      begin
         unique case (step_ff)
            app_pkg::APP_P_IDLE:
            begin
               if (running && angle_valid_i)
               begin
                  work_a_ff <= pre_angle;
                  seg_ref_ff <= opt_pick ? pre_angle : ext_encoder_angle_i;
                  step_ff <= app_pkg::APP_P_FILT;
               end
            end
            app_pkg::APP_P_FILT:
            begin
               work_a_ff <= opt_smooth ? filt_out : work_a_ff;
               filt_y_ff <= opt_smooth ? filt_out : work_a_ff;
               step_ff <= app_pkg::APP_P_SEG;
            end
            app_pkg::APP_P_SEG:
            begin
               work_a_ff <= lin_out;
               step_ff <= app_pkg::APP_P_POST;
            end
            app_pkg::APP_P_POST:
            begin
               work_a_ff <= opt_ss ? ss_out : post_angle;
               step_ff <= app_pkg::APP_P_FIN;
            end
            app_pkg::APP_P_FIN:
            begin
               step_ff <= app_pkg::APP_P_IDLE;
            end
            default:
            begin
               step_ff <= app_pkg::APP_P_IDLE;
            end
         endcase
      end
   end

   // Averaging and the final half-turn rotation.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         acc_ff <= 23'h000000;
         avg_cnt_ff <= 7'h00;
         angle_valid_o <= 1'b0;
         angle_o <= 16'h0000;
      end
      else if (ce_i)
      begin
         angle_valid_o <= 1'b0;
         if (!running)
         begin
            acc_ff <= 23'h000000;
            avg_cnt_ff <= 7'h00;
         end
         else if (step_ff == app_pkg::APP_P_FIN)
         begin
            if (avg_cnt_ff >= avg_last)
            begin
               acc_ff <= 23'h000000;
               avg_cnt_ff <= 7'h00;
               angle_valid_o <= 1'b1;
               angle_o <= opt_half ? 16'(avg_val + app_pkg::HALF_TURN) : avg_val;
            end
            else
            begin
               acc_ff <= acc_sum;
               avg_cnt_ff <= avg_cnt_ff + 7'h01;
            end
         end
      end
   end

endmodule : app_angle_post

`default_nettype wire

// ===== sim/app_angle_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module app_angle_monitor
(
   // Clock and reset.
   input wire logic core_clk_i, rst_b_i,
   // Bus handshakes.
   input wire logic awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i,
   input wire logic arvalid_i, arready_o, rvalid_o, rready_i,
   input wire logic [1:0] bresp_o,
   input wire logic [31:0] rdata_o,
   // Angle output.
   input wire logic angle_valid_o, init_done_o,
   input wire logic [15:0] angle_o
);
   int unsigned wait_ff;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Counts cycles spent without a finished initialization.
   always_ff @(posedge core_clk_i or negedge rst_b_i)
      if (!rst_b_i) wait_ff <= 0;
      else wait_ff <= init_done_o ? 0 : wait_ff + 1;
   sequence wr_take_s; awvalid_i && awready_o && wvalid_i && wready_o; endsequence
   sequence rd_take_s; arvalid_i && arready_o; endsequence
   wr_answer_a: assert property (wr_take_s |-> ##[1:2] bvalid_o) else $error("write answer late");
   rd_answer_a: assert property (rd_take_s |=> rvalid_o && !arready_o) else $error("read answer late");
   b_stands_a: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o)) else $error("bresp dropped");
   r_stands_a: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o)) else $error("rdata dropped");
   pulse_once_a: assert property (angle_valid_o |=> (!angle_valid_o) [*4]) else $error("pulse too long");
   run_only_a: assert property (angle_valid_o |-> init_done_o) else $error("angle before init");
   held_out_a: assert property ($changed(angle_o) |-> angle_valid_o) else $error("angle moved unflagged");
   selftest_a: assert property ($rose(init_done_o) |-> wait_ff >= 998 && wait_ff <= 1010) else $error("init time off");
endmodule : app_angle_monitor
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk_i = 0, rst_b_i = 0, angle_valid_i = 0, awvalid_i = 0, wvalid_i = 0, bready_i = 0;
   logic arvalid_i = 0, rready_i = 0, awready_o, wready_o, bvalid_o, arready_o, rvalid_o, angle_valid_o, init_done_o;
   logic [13:0] awaddr_i = 0, araddr_i = 0;
   logic [31:0] wdata_i = 0, rdata_o;
   logic [15:0] angle_i = 0, angle_o, last, enc = 16'h2000, hcorr = 16'h0100;
   logic [1:0] bresp_o, rresp_o;
   logic [23:0] opts [11] = '{24'h000ABC, 24'h001000, 24'h800ABC, 24'h040000, 24'h004000, 24'h020000, 24'h100000,
      24'h008000, 24'h210000, 24'h010000, 24'h410000};
   logic [15:0] expv [11] = '{16'h6674, 16'h02C7, 16'hE674, 16'hEDCB, 16'hEDCC, 16'hEDCC, 16'h2468, 16'h1334,
      16'h1244, 16'h1264, 16'h1284};
   int n_errors = 0, num_checks = 0, pulses;
   always #50 core_clk_i = ~core_clk_i;
   app_angle_post dut (.core_clk_i, .rst_b_i, .ce_i(1'h1), .angle_valid_i, .angle_i, .ext_encoder_angle_i(enc),
      .harmonic_corr_i(hcorr), .angle_valid_o, .angle_o, .init_done_o, .awvalid_i, .awready_o, .awaddr_i,
      .wvalid_i, .wready_o, .wdata_i, .wstrb_i(4'hF), .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o,
      .araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o);
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic tmo(input bit c);
      if (c)
      begin
         n_errors++;
         summarize();
      end
   endtask : tmo
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      int i;
      awaddr_i <= a;
      wdata_i <= d;
      {awvalid_i, wvalid_i, bready_i} <= 3'h7;
      do
      begin
         @(posedge core_clk_i);
         if (awready_o) awvalid_i <= 0;
         if (wready_o) wvalid_i <= 0;
         if (bvalid_o) bready_i <= 0;
      end
      while (bready_i && ++i < 40);
      tmo(i >= 40);
   endtask : wr
   task automatic rchk(input logic [13:0] a, input logic [31:0] exp, input logic [1:0] er);
      int i;
      araddr_i <= a;
      {arvalid_i, rready_i} <= 2'h3;
      do
      begin
         @(posedge core_clk_i);
         if (arready_o) arvalid_i <= 0;
         if (rvalid_o)
         begin
            rready_i <= 0;
            chk(rdata_o, exp);
            chk(rresp_o, er);
         end
      end
      while (rready_i && ++i < 40);
      tmo(i >= 40);
   endtask : rchk
   task automatic wait_init;
      int i;
      for (i = 0; i < 3000 && init_done_o !== 1'h1; i++) @(posedge core_clk_i);
      tmo(i >= 3000);
   endtask : wait_init
   task automatic reinit(input logic [23:0] o);
      wr(app_pkg::ADDR_OPTIONS, o);
      wr(app_pkg::ADDR_CTRL, 32'h1);
      repeat (3) @(posedge core_clk_i);
      wait_init();
   endtask : reinit
   task automatic send(input logic [15:0] a);
      angle_i <= a;
      angle_valid_i <= 1;
      @(posedge core_clk_i);
      angle_valid_i <= 0;
      repeat (7)
      begin
         @(posedge core_clk_i);
         if (angle_valid_o === 1'h1)
         begin
            pulses++;
            last = angle_o;
         end
      end
   endtask : send
   initial
   begin
      repeat (3) @(posedge core_clk_i);
      rst_b_i <= 1;
      wait_init();
      rchk(app_pkg::ADDR_OPTIONS, 32'h0, 2'h0);
      rchk(app_pkg::ADDR_RATE_TWO, 32'h156, 2'h0);
      rchk(app_pkg::ADDR_WORK_FILTER, 32'h156000AA, 2'h0);
      rchk(14'h0800, 32'h0, app_pkg::RESP_SLVERR);
      $display("test reset done");
      wr(app_pkg::ADDR_OPTIONS, 32'h000ABC);
      rchk(app_pkg::ADDR_WORK_ZERO, 32'h0, 2'h0);
      wr(app_pkg::ADDR_FILTER_ONE, 32'h5F1234);
      rchk(app_pkg::ADDR_FILTER_ONE, 32'h5F1234, 2'h0);
      reinit(24'h000ABC);
      rchk(app_pkg::ADDR_WORK_ZERO, 32'hABC0, 2'h0);
      rchk(app_pkg::ADDR_WORK_FILTER, 32'h156F1234, 2'h0);
      $display("test init copy done");
      wr(app_pkg::ADDR_GAIN, 32'h200);
      wr(app_pkg::ADDR_SEG_OFFSET, 32'h10);
      wr(app_pkg::ADDR_SEG_BASE + 14'h4, 32'h40);
      wr(app_pkg::ADDR_SEG_BASE + 14'h8, 32'h20);
      foreach (opts[k])
      begin
         reinit(opts[k]);
         send(16'h1234);
         chk(last, expv[k]);
      end
      $display("test angle path done");
      wr(app_pkg::ADDR_WORK_RATE, 32'h2);
      rchk(app_pkg::ADDR_WORK_RATE, 32'h2, 2'h0);
      pulses = 0;
      for (int j = 0; j < 4; j++) send(16'h1230 + 16'(4 * j));
      chk(pulses, 32'h1);
      chk(last, 32'h1286);
      $display("test averaging done");
      summarize();
   end
endmodule : testbench
bind app_angle_post app_angle_monitor mon (.core_clk_i, .rst_b_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o,
   .bvalid_o, .bready_i, .arvalid_i, .arready_o, .rvalid_o, .rready_i, .bresp_o, .rdata_o, .angle_valid_o,
   .init_done_o, .angle_o);
`default_nettype wire
